// [row_repair_pkg.sv]
package row_repair_pkg;

  // ----------------------------------------------------------------
  // command stream
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_MODE_SET, OP_ROW_OPEN, OP_STORE, OP_STORE_AUTOCLOSE, OP_READ,
    OP_CLOSE, OP_REFRESH, OP_IMPEDANCE_CAL, OP_IDLE, OP_RESERVED
  } op_t;

  typedef struct packed {
    logic        valid;        // one decoded command this cycle
    op_t         op;
    logic [1:0]  group_select;
    logic [1:0]  group_member_sel;
    logic [17:0] addr;
  } cmd_t;

  // ----------------------------------------------------------------
  // mode register and guard key constants
  // ----------------------------------------------------------------
  localparam logic [2:0]      MODE_REGISTER_ZERO = 3'h0;
  localparam logic [2:0]      MODE_REGISTER_FOUR = 3'h4;
  localparam int              HARD_ENABLE_BIT    = 13;
  localparam int              SOFT_ENABLE_BIT    = 5;
  localparam logic [6:0]      KEY_LOW_ONES       = 7'h7f;
  localparam logic [3:0][4:0] KEY_A11_7          = {5'h07, 5'h17, 5'h0f, 5'h19};
  localparam logic [1:0]      KEY_LAST_STEP      = 2'h3;
  localparam int              GROUP_COUNT        = 2;
  localparam int              ROW_WIDTH          = 18;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
  localparam logic [7:0]  FUSE_ROW_OFFSET = 8'h08;
  localparam logic [7:0]  SOFT_ROW_OFFSET = 8'h0c;
  localparam logic [7:0]  ABORTS_OFFSET   = 8'h10;
  localparam int          CTRL_ALLOW_BIT  = 0;
  localparam int          CTRL_RSEL_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h0;
  localparam logic [7:0]  ABORTS_RESET    = 8'h00;

endpackage : row_repair_pkg

// [fuse_row_store.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// repaired row memory, one word per bank group, registered read
// ------------------------------------------------------------------
module fuse_row_store
  import row_repair_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 we,
  input  wire logic                 waddr,
  input  wire logic [ROW_WIDTH-1:0] wdata,
  input  wire logic                 raddr,
  output logic      [ROW_WIDTH-1:0] rdata
);

  logic [ROW_WIDTH-1:0] mem [GROUP_COUNT];

  // array has no reset: it stands for nonvolatile fuse contents
  always_ff @(posedge pclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // read data from a register, one cycle behind raddr
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata <= '0;
    else
      rdata <= mem[raddr];
  end

endmodule : fuse_row_store
`default_nettype wire

// [row_repair_guard_key.sv]
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module row_repair_guard_key
  import row_repair_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire cmd_t        cmd_in,
  input  wire logic        fuse_factory_clear,
  output logic             repair_claim,
  output logic             fuse_program,
  output logic             hard_armed,
  output logic             soft_armed,
  output logic [7:0]       refresh_exclude,
  output logic             retention_lost
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_KEY, ST_HARD, ST_SOFT, ST_DONE} state_t;

  state_t                     state;
  state_t                     next_state;
  logic   [1:0]               key_step;
  logic   [1:0]               next_key_step;
  logic                       key_for_hard;
  logic                       mr4_hard;
  logic                       mr4_soft;
  logic                       hard_block;
  logic                       soft_block;
  logic   [GROUP_COUNT-1:0]   fused;
  logic                       target_valid;
  logic   [1:0]               target_bg;
  logic   [1:0]               target_ba;
  logic   [ROW_WIDTH-1:0]     target_row;
  logic   [ROW_WIDTH-1:0]     soft_row;
  logic                       soft_row_valid;
  logic   [1:0]               ctrl;
  logic   [7:0]               aborts;
  logic   [ROW_WIDTH-1:0]     fuse_rdata;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic is_mode_set(input cmd_t c, input logic [2:0] idx);
    is_mode_set = c.valid && (c.op == OP_MODE_SET) && ({c.group_select[0], c.group_member_sel} == idx);
  endfunction : is_mode_set

  wire mr4_write   = is_mode_set(cmd_in, MODE_REGISTER_FOUR);
  wire mr0_write   = is_mode_set(cmd_in, MODE_REGISTER_ZERO);
  wire new_hard    = cmd_in.addr[HARD_ENABLE_BIT];
  wire new_soft    = cmd_in.addr[SOFT_ENABLE_BIT];
  // group one bit is ignored on this x16 part
  wire key_hit     = mr0_write && (cmd_in.group_select[0] == 1'b0) && (cmd_in.group_member_sel == 2'h0)
                     && (cmd_in.addr[11:7] == KEY_A11_7[key_step])
                     && (cmd_in.addr[6:0] == KEY_LOW_ONES);
  wire key_miss    = (state == ST_KEY) && cmd_in.valid && !key_hit;
  wire allow       = ctrl[CTRL_ALLOW_BIT];
  wire hard_entry  = mr4_write && new_hard && !mr4_hard && !hard_block && allow;
  wire soft_entry  = mr4_write && new_soft && !mr4_soft && !soft_block && allow && !hard_entry;
  wire is_row_open = cmd_in.valid && (cmd_in.op == OP_ROW_OPEN);
  wire is_store    = cmd_in.valid && ((cmd_in.op == OP_STORE) || (cmd_in.op == OP_STORE_AUTOCLOSE));
  wire autoclose   = cmd_in.op == OP_STORE_AUTOCLOSE;
  // one fuse per bank group; a second repair in the group is dropped
  wire fuse_we     = (state == ST_HARD) && is_store && target_valid && !fused[target_bg[0]];
  wire mode_off    = mr4_write && (state != ST_KEY)
                     && ((key_for_hard && !new_hard) || (!key_for_hard && !new_soft));

  // repair only claims row opens and stores while armed; otherwise they run normally
  assign repair_claim = ((state == ST_HARD) || (state == ST_SOFT)) && (is_row_open || is_store);
  assign hard_armed   = state == ST_HARD;
  assign soft_armed   = state == ST_SOFT;

  // ----------------------------------------------------------------
  // guard key sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state    = state;
    next_key_step = key_step;
    unique case (state)
      ST_IDLE:
        if (hard_entry || soft_entry)
        begin
          next_state    = ST_KEY;
          next_key_step = '0;
        end
      ST_KEY:
        if (key_miss)
          next_state = ST_IDLE;
        else if (key_hit && (key_step == KEY_LAST_STEP))
          next_state = key_for_hard ? ST_HARD : ST_SOFT;
        else if (key_hit)
          next_key_step = key_step + 2'h1;
      ST_HARD:
        if (mode_off)
          next_state = ST_IDLE;
        else if (fuse_we)
          next_state = ST_DONE;
      ST_SOFT:
        if (mode_off)
          next_state = ST_IDLE;
        else if (is_row_open)
          next_state = ST_DONE;
      ST_DONE:
        if (mode_off)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // sequencer state and which repair the key belongs to
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= ST_IDLE;
      key_step     <= '0;
      key_for_hard <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      key_step <= next_key_step;
      if (state == ST_IDLE && (hard_entry || soft_entry))
        key_for_hard <= hard_entry;
    end
  end

  // mode register four shadow; a broken key locks that mode until its bit is written 0
  // abort set wins over a clearing write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mr4_hard   <= 1'b0;
      mr4_soft   <= 1'b0;
      hard_block <= 1'b0;
      soft_block <= 1'b0;
    end
    else
    begin
      if (mr4_write)
      begin
        mr4_hard <= new_hard;
        mr4_soft <= new_soft;
      end
      if (key_miss && key_for_hard)
        hard_block <= 1'b1;
      else if (mr4_write && !new_hard)
        hard_block <= 1'b0;
      if (key_miss && !key_for_hard)
        soft_block <= 1'b1;
      else if (mr4_write && !new_soft)
        soft_block <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // repair targets and fuse programming
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      target_valid    <= 1'b0;
      target_bg       <= '0;
      target_ba       <= '0;
      target_row      <= '0;
      soft_row        <= '0;
      soft_row_valid  <= 1'b0;
      fuse_program    <= 1'b0;
      refresh_exclude <= '0;
      retention_lost  <= 1'b0;
    end
    else
    begin
      fuse_program <= fuse_we;
      if (state == ST_HARD && is_row_open)
      begin
        target_valid <= 1'b1;
        target_bg    <= cmd_in.group_select;
        target_ba    <= cmd_in.group_member_sel;
        target_row   <= cmd_in.addr;
      end
      else if (state == ST_IDLE)
        target_valid <= 1'b0;
      if (state == ST_SOFT && is_row_open)
      begin
        soft_row       <= cmd_in.addr;
        soft_row_valid <= 1'b1;
      end
      // both banks sharing member bit 1 stay out of refresh
      if (fuse_we && autoclose)
        refresh_exclude <= 8'h03 << {target_bg[0], target_ba[1], 1'b0};
      else if (state == ST_IDLE)
        refresh_exclude <= '0;
      if (fuse_we && !autoclose)
        retention_lost <= 1'b1;
      else if (state == ST_IDLE)
        retention_lost <= 1'b0;
    end
  end

  // fuse marks have no reset: a programmed group stays programmed until a factory clear
  // a programming store wins over a factory clear in the same cycle
  always_ff @(posedge pclk)
  begin
    if (fuse_we)
      fused[target_bg[0]] <= 1'b1;
    else if (fuse_factory_clear)
      fused <= '0;
  end

  fuse_row_store u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (fuse_we),
    .waddr   (target_bg[0]),
    .wdata   (target_row),
    .raddr   (ctrl[CTRL_RSEL_BIT]),
    .rdata   (fuse_rdata)
  );

  // ----------------------------------------------------------------
  // apb slave: zero wait, read data captured in the setup cycle
  // ----------------------------------------------------------------
  wire apb_wr   = psel && penable && pwrite;
  wire hit_ctrl = paddr == CTRL_OFFSET;
  wire mapped   = hit_ctrl || (paddr == STATUS_OFFSET) || (paddr == FUSE_ROW_OFFSET)
                  || (paddr == SOFT_ROW_OFFSET) || (paddr == ABORTS_OFFSET);
  wire [31:0] status_word = {21'h000000, soft_row_valid, key_step, fused, retention_lost,
                             soft_block, hard_block, 1'b0, soft_armed, hard_armed};
  wire [31:0] rd_mux = hit_ctrl                     ? {30'h00000000, ctrl} :
                       (paddr == STATUS_OFFSET)     ? status_word :
                       (paddr == FUSE_ROW_OFFSET)   ? {14'h0000, fuse_rdata} :
                       (paddr == SOFT_ROW_OFFSET)   ? {14'h0000, soft_row} :
                       (paddr == ABORTS_OFFSET)     ? {24'h000000, aborts} : 32'h00000000;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // control, abort counter and read capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl   <= CTRL_RESET;
      aborts <= ABORTS_RESET;
      prdata <= '0;
    end
    else
    begin
      if (apb_wr && hit_ctrl)
        ctrl <= pwdata[1:0];
      if (key_miss && aborts != 8'hff)
        aborts <= aborts + 8'h01;
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_KEY_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
    key_miss |=> (state == ST_IDLE) && !hard_armed && !soft_armed)
    else $error("broken guard key did not return to idle");
  AST_KEY_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_KEY) && key_hit && (key_step != KEY_LAST_STEP) |=> (key_step == $past(key_step) + 2'h1))
    else $error("key step did not advance by one");
  AST_ONE_PER_GROUP: assert property (@(posedge pclk) disable iff (!presetn)
    fuse_program |-> $past(fused[target_bg[0]]) == 1'b0 ##0 fused[target_bg[0]])
    else $error("second fuse in one bank group");
  AST_FUSE_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    !fuse_factory_clear ##1 1'b1 |-> ((fused & $past(fused)) == $past(fused)))
    else $error("programmed fuse returned to blank");
  AST_EXCLUDE: assert property (@(posedge pclk) disable iff (!presetn)
    fuse_we && autoclose |=> ($countones(refresh_exclude) == 2) && !retention_lost)
    else $error("refresh exclusion not two banks");
  AST_RET_LOST: assert property (@(posedge pclk) disable iff (!presetn)
    fuse_we && !autoclose |=> retention_lost && (refresh_exclude == 8'h00))
    else $error("plain store sequence did not flag retention loss");
  AST_SHARED_KEY: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_KEY) && key_hit && (key_step == KEY_LAST_STEP) |=> (hard_armed != soft_armed)
    ##0 (hard_armed == $past(key_for_hard)))
    else $error("completed key armed the wrong mode");
  AST_NORMAL_CMDS: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_IDLE) || (state == ST_KEY) |-> !repair_claim)
    else $error("repair claimed a command while not armed");
  AST_FIRST_KEY: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_KEY) && (key_step == 2'h1) && ($past(key_step) == 2'h0) |->
    ($past(cmd_in.addr[11:7]) == 5'h19) && ($past(cmd_in.addr[6:0]) == 7'h7f))
    else $error("first key advanced on wrong pattern");
  AST_LAST_KEY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hard_armed || soft_armed) |-> $past(key_step) == 2'h3 ##0 $past(cmd_in.addr[11:7]) == 5'h07)
    else $error("repair armed without fourth key");

endmodule : row_repair_guard_key
`default_nettype wire

// [ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// controller model: drives the command stream
// ------------------------------------------------
module ctrl_model
  import row_repair_pkg::*;
(
  input  wire logic pclk,
  output cmd_t      cmd
);
  localparam logic [3:0][4:0] KEYS = {5'h07, 5'h17, 5'h0f, 5'h19};
  int spacing = 1;  // idle cycles after each command's release cycle

  initial cmd = '0;

  // released bus shows inverted fields, never the old command
  task automatic send(input op_t op, input logic [1:0] gs, input logic [1:0] gm,
                      input logic [17:0] a);
    @(posedge pclk);
    cmd <= '{1'b1, op, gs, gm, a};
    @(posedge pclk);
    cmd <= {1'b0, ~cmd[$bits(cmd_t)-2:0]};
    repeat (spacing) @(posedge pclk);
    #1;
  endtask : send

  // register index is {group_select[0], group_member_sel}
  task automatic mr(input logic [2:0] idx, input logic [17:0] a);
    send(OP_MODE_SET, {1'b0, idx[2]}, idx[1:0], a);
  endtask : mr

  // upper address bits set so that ignoring them is tested
  task automatic key(input int k);
    mr(MODE_REGISTER_ZERO, {1'b0, 5'h15, KEYS[k], 7'h7f});
  endtask : key

  // entry only when asked, never during bus training
  task automatic enter(input int bitpos, input int nkeys);
    send(OP_CLOSE, 2'h0, 2'h0, 18'h00400);
    mr(MODE_REGISTER_FOUR, 18'h1 << bitpos);
    for (int k = 0; k < nkeys; k++)
      key(k);
  endtask : enter

  // clear both enables, then restore normal mode zero contents
  task automatic leave();
    mr(MODE_REGISTER_FOUR, 18'h0);
    mr(MODE_REGISTER_ZERO, 18'h00a30);
  endtask : leave
endmodule : ctrl_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import row_repair_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        fuse_factory_clear = 1'b1;
  logic        pready, pslverr, repair_claim, fuse_program;
  logic        hard_armed, soft_armed, retention_lost, err;
  logic [31:0] prdata, rd;
  logic [7:0]  refresh_exclude;
  cmd_t        cmd_in;
  int          n_fail = 0, n_compared = 0, cycles = 0;
  int          n_prog = 0, n_claim = 0, c0 = 0;

  row_repair_guard_key DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cmd_in(cmd_in), .fuse_factory_clear(fuse_factory_clear), .repair_claim(repair_claim),
    .fuse_program(fuse_program), .hard_armed(hard_armed), .soft_armed(soft_armed),
    .refresh_exclude(refresh_exclude), .retention_lost(retention_lost)
  );
  ctrl_model u_ctrl (.pclk(pclk), .cmd(cmd_in));

  always #5 pclk = ~pclk;

  // pulse and claim counters; the hang guard ends a stuck run
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    n_prog <= n_prog + (fuse_program === 1'b1);
    n_claim <= n_claim + (cmd_in.valid === 1'b1 && repair_claim === 1'b1);
    if (cycles == 20000)
    begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  task automatic ck(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask : ck

  // setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    ck(s, rd & m, e);
  endtask : rg

  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    fuse_factory_clear <= 1'b0;
    rg(CTRL_OFFSET, 32'h3, 32'h0, "ctrl");
    rg(STATUS_OFFSET, 32'h7ff, 32'h0, "status");
    apb(1'b0, 8'h40, 32'h0);
    ck("unmapped", {err, rd[30:0]}, 32'h80000000);
    ck("ready", {31'h0, pready}, 32'h1);
    // entry refused until software allows it
    u_ctrl.enter(HARD_ENABLE_BIT, 4);
    ck("not allowed", {31'h0, hard_armed}, 32'h0);
    u_ctrl.leave();
    apb(1'b1, CTRL_OFFSET, 32'h1);
    // autoclose repair in group 0
    u_ctrl.enter(HARD_ENABLE_BIT, 4);
    ck("hard armed", {31'h0, hard_armed}, 32'h1);
    c0 = n_claim;
    u_ctrl.send(OP_ROW_OPEN, 2'h0, 2'h2, 18'h0abcd);
    u_ctrl.send(OP_STORE_AUTOCLOSE, 2'h0, 2'h2, 18'h0);
    ck("claims", n_claim - c0, 32'h2);
    ck("programs", n_prog, 32'h1);
    ck("refresh excl", {24'h0, refresh_exclude}, 32'h0c);
    ck("retention", {31'h0, retention_lost}, 32'h0);
    rg(FUSE_ROW_OFFSET, 32'h3ffff, 32'h0abcd, "fuse row");
    u_ctrl.leave();
    // a second row in the same group is dropped
    u_ctrl.enter(HARD_ENABLE_BIT, 4);
    u_ctrl.send(OP_ROW_OPEN, 2'h0, 2'h1, 18'h01111);
    u_ctrl.send(OP_STORE_AUTOCLOSE, 2'h0, 2'h1, 18'h0);
    ck("one per group", n_prog, 32'h1);
    ck("still armed", {31'h0, hard_armed}, 32'h1);
    u_ctrl.leave();
    ck("left", {31'h0, hard_armed}, 32'h0);
    // fuse marks survive a reset
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rg(STATUS_OFFSET, 32'hc0, 32'h40, "fused");
    // plain store repair in group 1 loses retention
    apb(1'b1, CTRL_OFFSET, 32'h3);
    u_ctrl.enter(HARD_ENABLE_BIT, 4);
    c0 = n_claim;
    u_ctrl.send(OP_ROW_OPEN, 2'h1, 2'h1, 18'h12345);
    u_ctrl.send(OP_STORE, 2'h1, 2'h1, 18'h0);
    ck("claims", n_claim - c0, 32'h2);
    ck("programs", n_prog, 32'h2);
    ck("retention", {31'h0, retention_lost}, 32'h1);
    rg(STATUS_OFFSET, 32'he0, 32'he0, "fused lost");
    rg(FUSE_ROW_OFFSET, 32'h3ffff, 32'h12345, "fuse row");
    u_ctrl.leave();
    ck("retention", {31'h0, retention_lost}, 32'h0);
    // key cut short: later row open and store run as normal
    c0 = n_claim;
    u_ctrl.enter(HARD_ENABLE_BIT, 2);
    u_ctrl.send(OP_ROW_OPEN, 2'h0, 2'h3, 18'h00777);
    u_ctrl.send(OP_STORE_AUTOCLOSE, 2'h0, 2'h3, 18'h0);
    ck("no claim", n_claim - c0, 32'h0);
    ck("not armed", {30'h0, hard_armed, soft_armed}, 32'h0);
    // enable bit left set: entry stays refused
    u_ctrl.enter(HARD_ENABLE_BIT, 4);
    ck("blocked", {31'h0, hard_armed}, 32'h0);
    u_ctrl.leave();
    // every kind of command breaks the key
    c0 = n_claim;
    for (int i = 0; i < 10; i++)
    begin
      u_ctrl.enter(i % 2 ? HARD_ENABLE_BIT : SOFT_ENABLE_BIT, 1 + i % 3);
      u_ctrl.send(op_t'(i), 2'h1, 2'h0, 18'h0);
      ck("broken", {30'h0, hard_armed, soft_armed}, 32'h0);
      u_ctrl.leave();
    end
    ck("no claim", n_claim - c0, 32'h0);
    u_ctrl.enter(SOFT_ENABLE_BIT, 1);
    u_ctrl.key(2);
    u_ctrl.key(3);
    ck("out of order", {31'h0, soft_armed}, 32'h0);
    u_ctrl.leave();
    rg(ABORTS_OFFSET, 32'hff, 32'h0c, "aborts");
    // soft repair with a slow controller
    u_ctrl.spacing = 3;
    u_ctrl.enter(SOFT_ENABLE_BIT, 4);
    ck("soft armed", {30'h0, hard_armed, soft_armed}, 32'h1);
    c0 = n_claim;
    u_ctrl.send(OP_ROW_OPEN, 2'h1, 2'h3, 18'h2f0f0);
    ck("soft claim", n_claim - c0, 32'h1);
    rg(SOFT_ROW_OFFSET, 32'h3ffff, 32'h2f0f0, "soft row");
    rg(STATUS_OFFSET, 32'h400, 32'h400, "soft valid");
    u_ctrl.leave();
    ck("soft left", {30'h0, hard_armed, soft_armed}, 32'h0);
    ck("programs", n_prog, 32'h2);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
